// [i2cf_fifo.sv]
// Small FIFO with a registered output stage.
`timescale 1ns/10ps
`default_nettype none
module i2cf_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : step

  assign in_ready = (cnt_q != FULL);
  assign push     = in_valid && in_ready;
  assign pop      = (cnt_q != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= step(wr_q);
      end
      if (pop) begin
        rd_q <= step(rd_q);
      end
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end

  // Output is a register so the consumer sees a clean flop.
  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem_q[rd_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule : i2cf_fifo
`default_nettype wire

// [i2cf_master_model.sv]
// Behavioural I2C bus master that drives the clock and data lines open-drain.
`timescale 1ns/10ps
`default_nettype none
module i2cf_master_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output var  logic scl_low,
  output var  logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // Quarter of the 80 ns link period, stepped just after a clock edge.
  task automatic qtr();
    repeat (2) @(posedge clk);
    #1;
  endtask : qtr
  // start framing.
  // The slave may hold its acknowledge a few cycles past the fall, so wait before rising.
  task automatic cond_start();
    sda_low = 1'b0;
    repeat (2) qtr();
    scl_low = 1'b0;
    qtr();
    sda_low = 1'b1;
    qtr();
    scl_low = 1'b1;
    qtr();
  endtask : cond_start
  task automatic cond_stop();
    sda_low = 1'b1;
    repeat (2) qtr();
    scl_low = 1'b0;
    qtr();
    sda_low = 1'b0;
    qtr();
  endtask : cond_stop
  // data only moves while the clock is low.
  task automatic send_bit(input logic b, output logic r);
    sda_low = !b;
    qtr();
    scl_low = 1'b0;
    qtr();
    r = sda_line;
    qtr();
    scl_low = 1'b1;
    qtr();
  endtask : send_bit
  // most significant bit first, then the acknowledge slot.
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      send_bit(v[i], r);
    end
    send_bit(1'b1, r);
    ack = !r;
  endtask : wr_byte
  // a master refusal ends the read.
  task automatic rd_byte(input logic ack_it, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      send_bit(1'b1, v[i]);
    end
    send_bit(!ack_it, r);
  endtask : rd_byte
endmodule : i2cf_master_model
`default_nettype wire

// [i2cf_pkg.sv]
// Shared types of the I2C slave bus front end.
`default_nettype none
package i2cf_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ADDR   = 3'h1,
    ST_RECV   = 3'h3,
    ST_SEND   = 3'h2,
    ST_HSWAIT = 3'h6,
    ST_IGNORE = 3'h7
  } i2cf_state_e;
  typedef logic [7:0] i2cf_byte_t;
endpackage : i2cf_pkg
`default_nettype wire

// [i2cf_regs.svh]
// Constants and field layout for the I2C slave bus front end.
// Operation
// - Data falling while clock high starts transfer.
// - Data rising while clock high stops transfer.
// - Stop returns whole interface to idle.
// - Data changes only while clock is low.
// - Ninth clock acknowledges by pulling data low.
// - After refusal, wait for a new start.
// - General call acknowledged only when enabled.
// - Repeated start collision resets the interface.
// - Start after a byte is repeated start.
// - Clock line is never held low.
// - Malformed or interrupted transfers are abandoned.
// - Address is fixed prefix plus pin bits.
// - Missing address pins compare as one.
// - Pin count per variant sets address layout.
// - Pin zero captured once after power-on.
// - Master code is refused, enters high speed.
// - Stop leaves high-speed mode.
// - High speed persists across repeated starts.
// - Data sampled on clock rising edge.
// - Address byte ends with direction bit.
// - Invalid command byte fields are refused.
`ifndef I2CF_REGS_SVH
`define I2CF_REGS_SVH
`define I2CF_PREFIX 4'h5
`define I2CF_HS_CODE 5'h01
`define I2CF_GC_ADDR 7'h00
`define I2CF_BITS 4'h8
`define I2CF_SETTLE 2'h3
`define I2CF_PULL 1'b1
`define I2CF_RW_BIT 0
`define I2CF_MEM_HI 7
`define I2CF_MEM_LO 4
`define I2CF_OP_HI 3
`define I2CF_OP_LO 2
`endif

// [i2cf_slave.sv]
// Bus-level I2C slave front end: conditions, addressing and acknowledge.
`timescale 1ns/10ps
`default_nettype none
`include "i2cf_regs.svh"
module i2cf_slave #(
  parameter int          ADDR_PINS = 3,
  parameter logic [63:0] CMD_MAP   = 64'hffff_ffff_ffff_ffff,
  parameter int          FIFO_DEPTH = 4
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                scl_i,
  output logic                     scl_o,
  output logic                     scl_oe,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe,
  input  wire logic                addr_pin_zero,
  input  wire logic                addr_pin_one,
  input  wire logic                addr_pin_two,
  input  wire logic                general_call_enable,
  input  wire i2cf_pkg::i2cf_byte_t tx_byte,
  output logic                     tx_take,
  output i2cf_pkg::i2cf_byte_t     rx_data,
  output logic                     rx_first,
  output logic                     rx_valid,
  input  wire logic                rx_ready,
  output logic                     hs_mode,
  output logic                     start_seen,
  output logic                     stop_seen,
  output logic                     frame_abort,
  output logic                     bus_collision,
  output logic                     selected,
  output logic                     read_mode
);
  import i2cf_pkg::*;

  i2cf_state_e state_q;
  i2cf_state_e nxt_q;
  i2cf_state_e nxt_d;
  i2cf_byte_t  shift_q;
  i2cf_byte_t  tx_q;
  logic [3:0]  cnt_q;
  logic [1:0]  bus_s;
  logic [1:0]  bus_r;
  logic [1:0]  bus_f;
  logic [2:0]  pins_s;
  logic [1:0]  settle_q;
  logic        pin0_q;
  logic        cap_q;
  logic        ack_q;
  logic        mack_q;
  logic        first_q;
  logic        gc_q;
  logic        ack_ok;
  logic        push_q;
  logic [8:0]  push_data_q;
  logic        fifo_ready;
  logic        scl_s;
  logic        sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        collide;
  logic        byte_done;
  logic        ack_end;
  logic        addr_hit;
  logic        gc_hit;
  logic        hs_hit;
  logic        busy;

  // Own address from prefix, pins and pulled-up gaps.
  function automatic logic [6:0] own_addr(input logic [2:0] p, input logic z);
    case (ADDR_PINS)
      1:       own_addr = {`I2CF_PREFIX, `I2CF_PULL, `I2CF_PULL, z};
      2:       own_addr = {`I2CF_PREFIX, `I2CF_PULL, p[1], z};
      default: own_addr = {`I2CF_PREFIX, p[2], p[1], z};
    endcase
  endfunction : own_addr

  // Command field pair looked up in the validity map.
  function automatic logic cmd_ok(input i2cf_byte_t b);
    cmd_ok = CMD_MAP[{b[`I2CF_MEM_HI:`I2CF_MEM_LO], b[`I2CF_OP_HI:`I2CF_OP_LO]}];
  endfunction : cmd_ok

  // Lines synchronised before any edge logic.
  i2cf_sync #(.W(2), .INIT(2'h3)) u_bus (
    .clk  (clk),
    .rst  (rst),
    .d    ({scl_i, sda_i}),
    .q    (bus_s),
    .rise (bus_r),
    .fall (bus_f)
  );

  i2cf_sync #(.W(3), .INIT(3'h7)) u_pins (
    .clk  (clk),
    .rst  (rst),
    .d    ({addr_pin_two, addr_pin_one, addr_pin_zero}),
    .q    (pins_s),
    .rise (),
    .fall ()
  );

  i2cf_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_q),
    .in_ready  (fifo_ready),
    .in_data   (push_data_q),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  ({rx_first, rx_data})
  );

  assign scl_s    = bus_s[1];
  assign sda_s    = bus_s[0];
  assign scl_rise = bus_r[1];
  assign scl_fall = bus_f[1];
  // Start: data falls while clock high.
  assign start_det = scl_s && bus_f[0];
  // Stop: data rises while clock high.
  assign stop_det  = scl_s && bus_r[0];
  // A clock fall, or a clock rise with data low, before the repeated start is a collision.
  assign collide   = (state_q == ST_HSWAIT) && ((scl_rise && !sda_s) || scl_fall);
  assign byte_done = scl_fall && (cnt_q == `I2CF_BITS) && !ack_q;
  assign ack_end   = scl_fall && ack_q;
  // Seven address bits above the direction bit.
  assign addr_hit  = (shift_q[7:1] == own_addr(pins_s, pin0_q));
  assign gc_hit    = (shift_q == {`I2CF_GC_ADDR, 1'b0});
  assign hs_hit    = (shift_q[7:3] == `I2CF_HS_CODE);
  assign busy      = (state_q != ST_IDLE) && (state_q != ST_IGNORE);

  // Pin zero caught once after reset; it later carries high voltage.
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_q <= 2'h0;
      pin0_q   <= 1'b1;
      cap_q    <= 1'b0;
    end else if (!cap_q) begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == `I2CF_SETTLE) begin
        pin0_q <= pins_s[0];
        cap_q  <= 1'b1;
      end
    end
  end

  // Bits shifted in on each clock rise outside the ack slot.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q   <= 4'h0;
      ack_q   <= 1'b0;
      shift_q <= 8'h00;
      mack_q  <= 1'b0;
    end else if (start_det || stop_det || collide) begin
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
    end else if (scl_rise && !ack_q) begin
      shift_q <= {shift_q[6:0], sda_s};
      cnt_q   <= cnt_q + 4'h1;
    end else if (scl_rise && ack_q) begin
      mack_q <= sda_s;
    end else if (byte_done) begin
      ack_q <= 1'b1;
    end else if (ack_end) begin
      ack_q <= 1'b0;
      cnt_q <= 4'h0;
    end
  end

  // Decision taken when eight bits are in.
  always_comb begin
    nxt_d  = state_q;
    ack_ok = 1'b0;
    case (state_q)
      ST_ADDR: begin
        if (hs_hit) begin
          nxt_d = ST_HSWAIT;
        end else if (addr_hit) begin
          ack_ok = 1'b1;
          nxt_d  = shift_q[`I2CF_RW_BIT] ? ST_SEND : ST_RECV;
        // General call only with its enable.
        end else if (gc_hit && general_call_enable) begin
          ack_ok = 1'b1;
          nxt_d  = ST_RECV;
        end else begin
          // Foreign address: stay off the bus.
          nxt_d = ST_IGNORE;
        end
      end
      ST_RECV: begin
        // Full buffer or bad command byte is refused.
        if ((first_q && !gc_q && !cmd_ok(shift_q)) || !fifo_ready) begin
          nxt_d = ST_IGNORE;
        end else begin
          ack_ok = 1'b1;
        end
      end
      default: begin
        nxt_d = state_q;
      end
    endcase
  end

  // Stop idles, any start restarts addressing.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      nxt_q   <= ST_IDLE;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
    end else if (start_det) begin
      state_q <= ST_ADDR;
    end else if (collide) begin
      state_q <= ST_IDLE;
    end else if (byte_done) begin
      nxt_q <= nxt_d;
    end else if (ack_end) begin
      state_q <= (state_q == ST_SEND && mack_q) ? ST_IGNORE : nxt_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      first_q   <= 1'b0;
      gc_q      <= 1'b0;
      read_mode <= 1'b0;
    end else if (byte_done && state_q == ST_ADDR) begin
      first_q   <= 1'b1;
      gc_q      <= gc_hit && !addr_hit;
      read_mode <= shift_q[`I2CF_RW_BIT];
    end else if (byte_done && state_q == ST_RECV) begin
      first_q <= 1'b0;
    end
  end

  // Data drive changes only after a clock fall.
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_oe  <= 1'b0;
      tx_q    <= 8'h00;
      tx_take <= 1'b0;
    end else begin
      tx_take <= 1'b0;
      if (start_det || stop_det || collide) begin
        sda_oe <= 1'b0;
      end else if (byte_done) begin
        sda_oe <= ack_ok;
      end else if (ack_end) begin
        if (nxt_q == ST_SEND && !(state_q == ST_SEND && mack_q)) begin
          tx_q    <= tx_byte;
          sda_oe  <= !tx_byte[7];
          tx_take <= 1'b1;
        end else begin
          sda_oe <= 1'b0;
        end
      end else if (scl_fall && state_q == ST_SEND && cnt_q != 4'h0) begin
        sda_oe <= !tx_q[3'(`I2CF_BITS - 4'h1 - cnt_q)];
      end
    end
  end

  // The clock line is only ever released.
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_o  <= 1'b0;
      scl_oe <= 1'b0;
      sda_o  <= 1'b0;
    end else begin
      scl_o  <= 1'b0;
      scl_oe <= 1'b0;
      sda_o  <= 1'b0;
    end
  end

  // Acknowledged bytes go to the buffer; it was checked for room above.
  always_ff @(posedge clk) begin
    if (rst) begin
      push_q      <= 1'b0;
      push_data_q <= 9'h000;
    end else begin
      push_q <= byte_done && state_q == ST_RECV && ack_ok;
      if (byte_done) begin
        push_data_q <= {first_q, shift_q};
      end
    end
  end

  // High speed ends only at stop.
  always_ff @(posedge clk) begin
    if (rst) begin
      hs_mode <= 1'b0;
    end else if (stop_det) begin
      hs_mode <= 1'b0;
    end else if (byte_done && state_q == ST_ADDR && hs_hit) begin
      hs_mode <= 1'b1;
    end
  end

  // A start or stop mid-byte abandons the transfer.
  always_ff @(posedge clk) begin
    if (rst) begin
      start_seen    <= 1'b0;
      stop_seen     <= 1'b0;
      frame_abort   <= 1'b0;
      bus_collision <= 1'b0;
      selected      <= 1'b0;
    end else begin
      start_seen    <= start_det;
      stop_seen     <= stop_det;
      frame_abort   <= (start_det || stop_det) && busy && (cnt_q != 4'h0 || ack_q);
      bus_collision <= collide && !start_det && !stop_det;
      selected      <= (state_q == ST_RECV) || (state_q == ST_SEND);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_addr_end;
    byte_done && state_q == ST_ADDR;
  endsequence

  sequence s_ack_slot;
    sda_oe[*1] ##1 !ack_end[*1];
  endsequence

  a_start_addr: assert property (
    start_det && !stop_det |=> state_q == ST_ADDR && cnt_q == 4'h0)
    else $error("start did not reset to addressing");

  a_stop_idle: assert property (
    stop_det |=> state_q == ST_IDLE && !sda_oe && !hs_mode)
    else $error("stop did not idle the interface");

  a_drive_low_clk: assert property (
    $rose(sda_oe) |-> !$past(scl_s))
    else $error("data drive changed with clock high");

  a_ack_match: assert property (
    s_addr_end and (addr_hit && !hs_hit) |=> s_ack_slot)
    else $error("matched address not acknowledged");

  a_gc_gate: assert property (
    s_addr_end and (gc_hit && !general_call_enable) |=> !sda_oe)
    else $error("general call answered while disabled");

  a_hs_enter: assert property (
    s_addr_end and hs_hit |=> hs_mode && !sda_oe)
    else $error("master code handling wrong");

  a_collide_reset: assert property (
    collide && !start_det && !stop_det |=> state_q == ST_IDLE && bus_collision)
    else $error("collision did not reset the interface");

  a_no_stretch: assert property (
    scl_fall |-> !scl_oe ##1 !scl_oe)
    else $error("clock line was driven");

  a_pin_zero_hold: assert property (
    cap_q && $past(cap_q) |-> $stable(pin0_q))
    else $error("pin zero capture changed");

  a_foreign_quiet: assert property (
    s_addr_end and (!addr_hit && !gc_hit && !hs_hit) |=> !sda_oe [*2])
    else $error("foreign address disturbed the bus");

  a_hs_keep: assert property (
    hs_mode && start_det && !stop_det |=> hs_mode)
    else $error("high speed lost at repeated start");
endmodule : i2cf_slave
`default_nettype wire

// [i2cf_sync.sv]
// Two-stage synchroniser with edge detection on the settled sample.
`timescale 1ns/10ps
`default_nettype none
module i2cf_sync #(
  parameter int           W    = 2,
  parameter logic [W-1:0] INIT = '1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  // The first stage feeds only the second; edges come from later stages.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= INIT;
      sync_q <= INIT;
      last_q <= INIT;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign q    = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule : i2cf_sync
`default_nettype wire

// [tb_i2c_slave_bus_front_end.sv]
// Self-checking bench for the I2C slave bus front end.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_i2c_slave_bus_front_end;
  import i2cf_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic       gce;
    logic       ack;
    logic       hs;
  } i2cf_row_s;
  logic         clk, rst, scl_low, sda_low, addr_pin_zero, general_call_enable, rx_ready;
  logic         scl_o, scl_oe, sda_o, sda_oe, sda_o2, sda_oe2, tx_take, rx_first, rx_valid;
  logic         hs_mode, start_seen, stop_seen, frame_abort, bus_collision, selected, read_mode;
  logic         addr_pin_one, addr_pin_two;
  i2cf_byte_t   tx_byte, rx_data;
  wire logic    scl_line, sda_line;
  int           bad_count, checks, start_n, stop_n, abort_n, coll_n, hold_n;
  i2cf_row_s    rows [8];
  // The data line is pulled up; every party can only pull it low.
  assign scl_line = !scl_low && !(scl_oe && !scl_o);
  assign sda_line = !sda_low && !(sda_oe && !sda_o) && !(sda_oe2 && !sda_o2);
  i2cf_slave dut_u (.clk(clk), .rst(rst), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .addr_pin_zero(addr_pin_zero),
    .addr_pin_one(addr_pin_one), .addr_pin_two(addr_pin_two),
    .general_call_enable(general_call_enable),
    .tx_byte(tx_byte), .tx_take(tx_take), .rx_data(rx_data), .rx_first(rx_first),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .hs_mode(hs_mode), .start_seen(start_seen),
    .stop_seen(stop_seen), .frame_abort(frame_abort), .bus_collision(bus_collision),
    .selected(selected), .read_mode(read_mode));
  // A one-pin variant shares the bus; its missing pins must compare as one.
  // It also refuses the command byte whose fields index the top map bit.
  i2cf_slave #(.ADDR_PINS(1), .CMD_MAP(64'h7fff_ffff_ffff_ffff)) dut2_u (.clk(clk), .rst(rst),
    .scl_i(scl_line), .scl_o(), .scl_oe(), .sda_i(sda_line), .sda_o(sda_o2), .sda_oe(sda_oe2),
    .addr_pin_zero(addr_pin_zero), .addr_pin_one(addr_pin_one), .addr_pin_two(addr_pin_two),
    .general_call_enable(general_call_enable), .tx_byte(8'h00), .tx_take(), .rx_data(),
    .rx_first(), .rx_valid(), .rx_ready(1'b1), .hs_mode(), .start_seen(), .stop_seen(),
    .frame_abort(), .bus_collision(), .selected(), .read_mode());
  i2cf_master_model m_u (.clk(clk), .sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low));
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  always @(posedge clk) begin
    if (start_seen === 1'b1) start_n++;
    if (stop_seen === 1'b1) stop_n++;
    if (frame_abort === 1'b1) abort_n++;
    if (bus_collision === 1'b1) coll_n++;
    // the clock line is never held.
    if (rst === 1'b0 && scl_oe !== 1'b0) hold_n++;
    if (rst === 1'b1) tx_byte <= #1 8'ha6;
    else if (tx_take === 1'b1) tx_byte <= #1 tx_byte + 8'h11;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic wait_valid();
    for (int j = 0; j < 60; j++) begin
      if (rx_valid === 1'b1) return;
      settle(1);
    end
    bad_count++;
    $display("[FAIL] rx_valid wait ran out");
    tally_and_finish();
  endtask : wait_valid
  initial begin
    logic       ack;
    logic       r;
    i2cf_byte_t v;
    int         n0, n1, n2;
    rst = 1'b1;
    addr_pin_zero = 1'b1;
    general_call_enable = 1'b0;
    rx_ready = 1'b0;
    addr_pin_one = 1'b0;
    addr_pin_two = 1'b1;
    rows = '{'{8'h5a, 1'b0, 1'b1, 1'b0}, '{8'h58, 1'b0, 1'b0, 1'b0},
             '{8'h5c, 1'b0, 1'b0, 1'b0}, '{8'h4a, 1'b0, 1'b0, 1'b0},
             '{8'h5e, 1'b0, 1'b1, 1'b0}, '{8'h00, 1'b0, 1'b0, 1'b0},
             '{8'h00, 1'b1, 1'b1, 1'b0}, '{8'h0f, 1'b0, 1'b0, 1'b1}};
    settle(2);
    `CHK("sda_oe in reset", 1'b0, sda_oe)
    `CHK("selected in reset", 1'b0, selected)
    rst = 1'b0;
    settle(10);
    // Pin zero moves after its capture; the latched value must still decide the address.
    addr_pin_zero = 1'b0;
    for (int i = 0; i < 8; i++) begin
      general_call_enable = rows[i].gce;
      m_u.cond_start();
      m_u.wr_byte(rows[i].addr, ack);
      `CHK("address ack", rows[i].ack, ack)
      `CHK("hs after code", rows[i].hs, hs_mode)
      m_u.cond_stop();
      settle(8);
      `CHK("hs after stop", 1'b0, hs_mode)
    end
    general_call_enable = 1'b0;
    n0 = start_n;
    n1 = stop_n;
    m_u.cond_start();
    m_u.wr_byte(8'h5a, ack);
    for (int i = 0; i < 6; i++) begin
      m_u.wr_byte(8'h30 + 8'(i), ack);
      `CHK("fifo byte ack", 1'(i < 5), ack)
    end
    m_u.wr_byte(8'h77, ack);
    `CHK("ignored after refusal", 1'b0, ack)
    m_u.cond_start();
    m_u.wr_byte(8'h5a, ack);
    `CHK("repeated start ack", 1'b1, ack)
    m_u.cond_stop();
    settle(8);
    `CHK("start count", 2, start_n - n0)
    `CHK("stop count", 1, stop_n - n1)
    `CHK("idle after stop", 1'b0, selected)
    rx_ready = 1'b1;
    for (int i = 0; i < 5; i++) begin
      wait_valid();
      `CHK("rx data", 8'h30 + 8'(i), rx_data)
      `CHK("rx first", 1'(i == 0), rx_first)
      settle(1);
    end
    settle(12);
    `CHK("fifo empty", 1'b0, rx_valid)
    m_u.cond_start();
    m_u.wr_byte(8'h5b, ack);
    `CHK("read address ack", 1'b1, ack)
    `CHK("read mode", 1'b1, read_mode)
    m_u.rd_byte(1'b1, v);
    `CHK("read byte one", 8'ha6, v)
    m_u.rd_byte(1'b0, v);
    `CHK("read byte two", 8'hb7, v)
    m_u.cond_stop();
    n0 = abort_n;
    m_u.cond_start();
    m_u.wr_byte(8'h5a, ack);
    for (int i = 0; i < 4; i++) begin
      m_u.send_bit(1'(i % 2), r);
    end
    m_u.cond_stop();
    settle(12);
    `CHK("abort pulse", 1, abort_n - n0)
    `CHK("nothing pushed", 1'b0, rx_valid)
    // The one-pin device refuses a bad command pair and stays deaf until a new start.
    m_u.cond_start();
    m_u.wr_byte(8'h5e, ack);
    `CHK("one-pin address ack", 1'b1, ack)
    m_u.wr_byte(8'hfc, ack);
    `CHK("bad command refused", 1'b0, ack)
    m_u.wr_byte(8'h30, ack);
    `CHK("ignored after bad command", 1'b0, ack)
    m_u.cond_start();
    m_u.wr_byte(8'h5e, ack);
    m_u.wr_byte(8'h30, ack);
    `CHK("good command ack", 1'b1, ack)
    m_u.cond_stop();
    for (int b = 0; b < 2; b++) begin
      n2 = coll_n;
      m_u.cond_start();
      m_u.wr_byte(8'h08, ack);
      `CHK("code refused", 1'b0, ack)
      m_u.send_bit(1'(b), r);
      settle(6);
      `CHK("collision", 1, coll_n - n2)
      m_u.cond_stop();
    end
    m_u.cond_start();
    m_u.wr_byte(8'h0a, ack);
    m_u.cond_start();
    m_u.wr_byte(8'h5a, ack);
    `CHK("hs address ack", 1'b1, ack)
    `CHK("hs kept", 1'b1, hs_mode)
    m_u.cond_stop();
    settle(8);
    `CHK("hs left", 1'b0, hs_mode)
    `CHK("clock never held", 0, hold_n)
    tally_and_finish();
  end
endmodule : tb_i2c_slave_bus_front_end
`default_nettype wire
